// File: rtl/aof_pkg.sv
// Functional notes
// - Three output modes, picked by a register field or the serial-clock pin level.
// - Pin configuration never reaches double-data-rate single-ended mode.
// - Full-rate mode drives twelve bits, overflow and a true/complement clock pair.
// - DDR single-ended mode carries two bits on each of six outputs.
// - DDR differential mode uses six data pairs plus overflow and clock pairs.
// - Stabilizer needs one hundred encode cycles to relock after a clock change.
// - Stabilizer enable comes from a register bit or the chip-select pin level.
// - Stabilizer accepts 30% to 70% duty and keeps 50% internally.
// - In DDR modes even bits show while the clock is low, odd bits while high.
// - In full-rate mode data changes on the falling edge of the forwarded clock.
// - In pin configuration low selects full-rate, high selects DDR differential.
// - In pin configuration low chip-select turns the stabilizer off, high on.
package aof_pkg;
  localparam int DATA_W = 12;
  localparam int LANE_W = 6;
  localparam int LOCK_CYCLES = 100;
  localparam int SYNC_W = 3;
  localparam logic [1:0] MODE_FULL_CMOS = 2'h0;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h2;
  typedef enum logic [1:0] {AOF_FULL, AOF_DDR_SE, AOF_DDR_DIFF} aof_mode_e;
endpackage : aof_pkg

// File: rtl/aof_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output changes only once stages two and three agree.
module aof_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  import aof_pkg::*;
  logic [aof_pkg::SYNC_W-1:0] stage;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= {aof_pkg::SYNC_W{RESET_VAL}};
    end else begin
      stage <= {stage[aof_pkg::SYNC_W-2:0], din};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout <= RESET_VAL;
    end else if (stage[1] == stage[2]) begin
      dout <= stage[2];
    end
  end
endmodule : aof_sync

// File: rtl/aof_formatter.sv
`timescale 1ns/1ps
module aof_formatter #(
  parameter int LOCK_CYCLES = aof_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic encode_clk_p,
  input wire logic [aof_pkg::DATA_W-1:0] sample_data,
  input wire logic sample_overflow,
  input wire logic config_style_select,
  input wire logic [1:0] output_mode_field,
  input wire logic stabilizer_enable_bit,
  input wire logic pin_sck_level,
  input wire logic pin_cs_level,
  output logic [aof_pkg::DATA_W-1:0] full_data_out,
  output logic [aof_pkg::LANE_W-1:0] ddr_pair_lane,
  output logic [aof_pkg::LANE_W-1:0] ddr_pair_lane_n,
  output logic range_overflow_out,
  output logic range_overflow_out_n,
  output logic fwd_clk_true,
  output logic fwd_clk_comp,
  output logic [1:0] active_mode,
  output logic stabilizer_on,
  output logic stabilizer_locked,
  output logic data_valid
);
  import aof_pkg::*;

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic enc_s;
  logic enc_d;
  logic cfg_pin_s;
  logic sck_s;
  logic cs_s;

  aof_sync #(.RESET_VAL(1'b0)) u_enc (.clk(clk), .arst_n(arst_n), .din(encode_clk_p), .dout(enc_s));
  aof_sync #(.RESET_VAL(1'b0)) u_cfg (.clk(clk), .arst_n(arst_n), .din(config_style_select), .dout(cfg_pin_s));
  aof_sync #(.RESET_VAL(1'b0)) u_sck (.clk(clk), .arst_n(arst_n), .din(pin_sck_level), .dout(sck_s));
  aof_sync #(.RESET_VAL(1'b0)) u_cs (.clk(clk), .arst_n(arst_n), .din(pin_cs_level), .dout(cs_s));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_d <= 1'b0;
    end else begin
      enc_d <= enc_s;
    end
  end

  logic enc_rise;
  logic enc_fall;
  assign enc_rise = enc_s & ~enc_d;
  assign enc_fall = ~enc_s & enc_d;

  // ==========================================================
  // Mode and stabilizer selection
  // ==========================================================
  function automatic logic [1:0] pick_mode(input logic pin_cfg, input logic sck, input logic [1:0] field);
    if (pin_cfg) begin
      pick_mode = sck ? MODE_DDR_LVDS : MODE_FULL_CMOS;
    end else if (field == MODE_DDR_CMOS || field == MODE_DDR_LVDS) begin
      pick_mode = field;
    end else begin
      pick_mode = MODE_FULL_CMOS;
    end
  endfunction : pick_mode

  logic [1:0] next_mode;
  logic [1:0] mode_q;
  logic next_stab;
  assign next_mode = pick_mode(cfg_pin_s, sck_s, output_mode_field);
  assign next_stab = cfg_pin_s ? cs_s : stabilizer_enable_bit;

  // Mode is only updated on an encode rising edge, which starts a new sample word.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_FULL_CMOS;
    end else if (enc_rise) begin
      mode_q <= next_mode;
    end
  end

  // The reported mode trails by one clock so it changes with the first output of the new word.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_mode <= MODE_FULL_CMOS;
    end else begin
      active_mode <= mode_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stabilizer_on <= 1'b0;
    end else begin
      stabilizer_on <= next_stab;
    end
  end

  // ==========================================================
  // Stabilizer lock tracking
  // ==========================================================
  // The encode period is measured in system clocks; any change, or a stop, restarts the lock count.
  localparam int PER_W = 16;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] per_last;
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt;
  logic clk_lost;
  assign clk_lost = (per_cnt == {PER_W{1'b1}});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt <= '0;
    end else if (enc_rise) begin
      per_cnt <= '0;
    end else if (!clk_lost) begin
      per_cnt <= per_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      per_last <= '0;
    end else if (enc_rise) begin
      per_last <= per_cnt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt <= '0;
    end else if (!stabilizer_on || clk_lost || (enc_rise && per_cnt != per_last)) begin
      lock_cnt <= '0;
    end else if (enc_rise && lock_cnt != LOCK_CYCLES[$bits(lock_cnt)-1:0]) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stabilizer_locked <= 1'b0;
    end else begin
      stabilizer_locked <= stabilizer_on && (lock_cnt == LOCK_CYCLES[$bits(lock_cnt)-1:0]);
    end
  end

  // Stabilizer mode derives the forwarded clock halfway through the measured period (50% duty).
  logic half_point;
  assign half_point = stabilizer_locked && (per_cnt == (per_last >> 1)) && !enc_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= (!stabilizer_on || stabilizer_locked) && !clk_lost;
    end
  end

  // ==========================================================
  // Output formatting
  // ==========================================================
  logic [DATA_W-1:0] word;
  logic word_ovf;
  logic clk_high;
  logic clk_fall_ev;
  logic clk_rise_ev;

  assign clk_fall_ev = enc_rise;
  // Until the stabilizer has locked the forwarded clock follows the encode fall, so it never stalls.
  assign clk_rise_ev = stabilizer_locked ? half_point : enc_fall;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word <= '0;
      word_ovf <= 1'b0;
    end else if (enc_rise) begin
      word <= sample_data;
      word_ovf <= sample_overflow;
    end
  end

  // Starts high so that the first word after reset also opens on a falling forwarded clock.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_high <= 1'b1;
    end else if (clk_fall_ev) begin
      clk_high <= 1'b0;
    end else if (clk_rise_ev) begin
      clk_high <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_clk_true <= 1'b0;
      fwd_clk_comp <= 1'b1;
    end else begin
      fwd_clk_true <= clk_high;
      fwd_clk_comp <= ~clk_high;
    end
  end

  // Full-rate word follows the captured sample one clock later, in step with the forwarded clock fall.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_data_out <= '0;
    end else if (mode_q != MODE_FULL_CMOS) begin
      full_data_out <= '0;
    end else begin
      full_data_out <= word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      range_overflow_out <= 1'b0;
      range_overflow_out_n <= 1'b1;
    end else begin
      range_overflow_out <= word_ovf;
      range_overflow_out_n <= (mode_q == MODE_DDR_LVDS) ? ~word_ovf : 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANE_W; g++) begin : g_lane
      logic bit_now;
      assign bit_now = clk_high ? word[2*g+1] : word[2*g];
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ddr_pair_lane[g] <= 1'b0;
          ddr_pair_lane_n[g] <= 1'b1;
        end else if (mode_q == MODE_FULL_CMOS) begin
          ddr_pair_lane[g] <= 1'b0;
          ddr_pair_lane_n[g] <= 1'b1;
        end else begin
          ddr_pair_lane[g] <= bit_now;
          ddr_pair_lane_n[g] <= (mode_q == MODE_DDR_LVDS) ? ~bit_now : 1'b1;
        end
      end
    end
  endgenerate
endmodule : aof_formatter

// File: dv/aof_formatter_asserts.sv
`timescale 1ns/1ps
module aof_chk #(
  parameter int LOCK_CYCLES = aof_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic encode_clk_p,
  input wire logic config_style_select,
  input wire logic pin_cs_level,
  input wire logic [aof_pkg::DATA_W-1:0] full_data_out,
  input wire logic [aof_pkg::LANE_W-1:0] ddr_pair_lane,
  input wire logic [aof_pkg::LANE_W-1:0] ddr_pair_lane_n,
  input wire logic range_overflow_out,
  input wire logic range_overflow_out_n,
  input wire logic fwd_clk_true,
  input wire logic fwd_clk_comp,
  input wire logic [1:0] active_mode,
  input wire logic stabilizer_on,
  input wire logic stabilizer_locked
);
  import aof_pkg::*;
  logic enc_q;
  int enc_cnt;
  // Counts raw encode rises while the stabilizer is on; never more than one below the design's own count.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enc_q <= 1'b0;
      enc_cnt <= 0;
    end else begin
      enc_q <= encode_clk_p;
      enc_cnt <= stabilizer_on ? enc_cnt + int'(encode_clk_p && !enc_q) : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence pin_on_s; (config_style_select && pin_cs_level) [*8]; endsequence
  sequence pin_off_s; (config_style_select && !pin_cs_level) [*8]; endsequence
  chk_clk_pair: assert property (fwd_clk_comp == !fwd_clk_true) else $error("clock pair broken");
  chk_full_lanes: assert property (active_mode == MODE_FULL_CMOS |-> ddr_pair_lane == '0)
    else $error("lanes busy in full mode");
  chk_ddr_nofull: assert property (active_mode != MODE_FULL_CMOS |-> full_data_out == '0)
    else $error("full bus busy in ddr");
  chk_diff_pairs: assert property (active_mode == MODE_DDR_LVDS |-> ddr_pair_lane_n == ~ddr_pair_lane
    && range_overflow_out_n == !range_overflow_out) else $error("pair not complementary");
  chk_full_edge: assert property (active_mode == MODE_FULL_CMOS && $stable(active_mode)
    && $changed(full_data_out) |-> $fell(fwd_clk_true)) else $error("data off clock fall");
  chk_mode_edge: assert property ($changed(active_mode) |-> !fwd_clk_true) else $error("mode mid word");
  chk_pin_on: assert property (pin_on_s |-> stabilizer_on) else $error("stabilizer not on");
  chk_pin_off: assert property (pin_off_s |-> !stabilizer_on) else $error("stabilizer not off");
  chk_lock_count: assert property ($rose(stabilizer_locked) |-> enc_cnt >= LOCK_CYCLES - 1)
    else $error("lock too early");
endmodule : aof_chk
bind aof_formatter aof_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
  .encode_clk_p(encode_clk_p), .config_style_select(config_style_select), .pin_cs_level(pin_cs_level),
  .full_data_out(full_data_out), .ddr_pair_lane(ddr_pair_lane), .ddr_pair_lane_n(ddr_pair_lane_n),
  .range_overflow_out(range_overflow_out), .range_overflow_out_n(range_overflow_out_n),
  .fwd_clk_true(fwd_clk_true), .fwd_clk_comp(fwd_clk_comp), .active_mode(active_mode),
  .stabilizer_on(stabilizer_on), .stabilizer_locked(stabilizer_locked));

// File: dv/aof_rx_model.sv
`timescale 1ns/1ps
module aof_rx_model (
  input wire logic clk,
  input wire logic fwd_clk_true,
  input wire logic [aof_pkg::DATA_W-1:0] full_data_out,
  input wire logic [aof_pkg::LANE_W-1:0] ddr_pair_lane,
  output logic [aof_pkg::DATA_W-1:0] rx_full,
  output logic [aof_pkg::DATA_W-1:0] rx_ddr
);
  import aof_pkg::*;
  logic fclk_q;
  always @(posedge clk) begin
    fclk_q <= fwd_clk_true;
    if (fwd_clk_true && !fclk_q) rx_full <= full_data_out;
    for (int g = 0; g < LANE_W; g++) begin
      if (fwd_clk_true) rx_ddr[2*g+1] <= ddr_pair_lane[g];
      else rx_ddr[2*g] <= ddr_pair_lane[g];
    end
  end
endmodule : aof_rx_model

// File: dv/tb_aof_formatter.sv
`timescale 1ns/1ps
module tb_aof_formatter;
  import aof_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, enc = 1'b0, run = 1'b1, ovf = 1'b0, cfg = 1'b0, sbit = 1'b0, sck = 1'b0, cs = 1'b0;
  logic [DATA_W-1:0] smp = 12'h0, full_o, rx_full, rx_ddr;
  logic [LANE_W-1:0] lane, lane_n;
  logic ovf_o, ovf_n, fclk, fclk_n, stab_on, locked, valid;
  logic [1:0] mode_f = 2'h0, mode_o;
  int n_errors = 0;
  int check_count = 0;
  aof_formatter uut (.clk(clk), .arst_n(arst_n), .encode_clk_p(enc), .sample_data(smp), .sample_overflow(ovf),
    .config_style_select(cfg), .output_mode_field(mode_f), .stabilizer_enable_bit(sbit), .pin_sck_level(sck),
    .pin_cs_level(cs), .full_data_out(full_o), .ddr_pair_lane(lane), .ddr_pair_lane_n(lane_n),
    .range_overflow_out(ovf_o), .range_overflow_out_n(ovf_n), .fwd_clk_true(fclk), .fwd_clk_comp(fclk_n),
    .active_mode(mode_o), .stabilizer_on(stab_on), .stabilizer_locked(locked), .data_valid(valid));
  aof_rx_model rx (.clk(clk), .fwd_clk_true(fclk), .full_data_out(full_o), .ddr_pair_lane(lane),
    .rx_full(rx_full), .rx_ddr(rx_ddr));
  initial forever #10 clk = ~clk;
  // Encode clock of 160 ns; run low freezes it to force a relock.
  initial forever begin
    repeat (4) @(negedge clk);
    if (run) enc = ~enc;
  end
  task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      smp = 12'hA5C ^ 12'(m * 273);
      ovf = m[0];
      mode_f = 2'(m);
      repeat (40) @(negedge clk);
      chk("active_mode", 12'(mode_o), (m == 3) ? 12'h0 : 12'(m));
      chk("rx_word", (m % 3 == 0) ? rx_full : rx_ddr, smp);
      chk("overflow", 12'(ovf_o), 12'(m % 2));
    end
  endtask : t_modes
  task automatic t_pin();
    cfg = 1'b1;
    mode_f = MODE_DDR_CMOS;
    for (int s = 0; s < 2; s++) begin
      sck = s[0];
      cs = s[0];
      repeat (40) @(negedge clk);
      chk("pin_mode", 12'(mode_o), s ? 12'(MODE_DDR_LVDS) : 12'(MODE_FULL_CMOS));
      chk("pin_stab", 12'(stab_on), 12'(s));
    end
    cs = 1'b0;
    cfg = 1'b0;
  endtask : t_pin
  task automatic t_stab();
    sbit = 1'b1;
    repeat (720) @(negedge clk);
    chk("stab_on", 12'(stab_on), 12'h1);
    chk("lock_early", 12'(locked), 12'h0);
    chk("valid_early", 12'(valid), 12'h0);
    repeat (200) @(negedge clk);
    chk("locked", 12'(locked), 12'h1);
    chk("valid", 12'(valid), 12'h1);
    chk("rx_locked", rx_ddr, smp);
    run = 1'b0;
    repeat (40) @(negedge clk);
    run = 1'b1;
    repeat (160) @(negedge clk);
    chk("relock", 12'(locked), 12'h0);
  endtask : t_stab
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(negedge clk);
    chk("reset_comp", 12'(fclk_n), 12'h1);
    arst_n = 1'b1;
    t_modes();
    t_pin();
    t_stab();
    end_sim();
  end
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : tb_aof_formatter
